// *** logic/lac_pkg.sv ***
package lac_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ = 20000;
  localparam int LONG_PRESS_MS = 1000;
  localparam int LONG_PRESS_CYC = LONG_PRESS_MS * CLK_KHZ;
  localparam int TEST_PHASE_MS = 1000;
  localparam int TEST_PHASE_CYC = TEST_PHASE_MS * CLK_KHZ;
  localparam int OFF_DELAY_MS = 100;
  localparam int OFF_DELAY_CYC = OFF_DELAY_MS * CLK_KHZ;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [2:0] ADR_CTRL = 3'h0;
  localparam logic [2:0] ADR_AUTO = 3'h1;
  localparam logic [2:0] ADR_CMD = 3'h2;
  localparam logic [2:0] ADR_LED_STAT = 3'h3;
  localparam logic [2:0] ADR_MISC_STAT = 3'h4;

  localparam int CTRL_REMOTE_EN = 0;
  localparam int CTRL_SCOPE_LSB = 1;
  localparam int CTRL_LV1_EMPTY = 4;

  localparam int CMD_SYS = 0;
  localparam int CMD_LED = 1;
  localparam int CMD_REL = 2;
  localparam int CMD_SCD = 3;
  localparam int CMD_TRIP = 4;
  localparam int CMD_ALL = 5;
  localparam int CMD_SG_LSB = 8;

  localparam int ST_REL_LSB = 0;
  localparam int ST_SCD_LSB = 8;
  localparam int ST_TRIP_LSB = 16;
  localparam int ST_MENU = 24;
  localparam int ST_TEST = 25;
  localparam int ST_SYS = 26;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    scope_nothing,
    scope_indicators_no_password,
    scope_indicators_password,
    scope_indicators_and_relays,
    scope_everything
  } lac_scope_e;

  localparam lac_scope_e SCOPE_RESET = scope_indicators_no_password;

  typedef struct packed {
    logic sys;
    logic led;
    logic rel;
    logic scd;
    logic trip;
  } lac_cat_s;

endpackage : lac_pkg

// *** logic/lac_key_press.sv ***
`timescale 1ns/1ps
module lac_key_press
  import lac_pkg::*;
#(
  parameter int LONG_CYC = LONG_PRESS_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Key pin
  input wire logic key_pin_i,
  // Classified presses
  output logic short_o,
  output logic long_o
);

  logic sync1_reg;
  logic sync2_reg;
  logic [31:0] cnt_reg;
  logic long_done_reg;

  // ****************************************
  // Synchroniser
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= key_pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************
  // Hold counter
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 32'h0;
      long_done_reg <= 1'b0;
      short_o <= 1'b0;
      long_o <= 1'b0;
    end else begin
      short_o <= 1'b0;
      long_o <= 1'b0;
      if (sync2_reg) begin
        if (!long_done_reg) begin
          if (cnt_reg == 32'(LONG_CYC - 1)) begin
            long_o <= 1'b1;
            long_done_reg <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
      end else begin
        if (!long_done_reg && cnt_reg != 32'h0) begin
          short_o <= 1'b1;
        end
        cnt_reg <= 32'h0;
        long_done_reg <= 1'b0;
      end
    end
  end

endmodule : lac_key_press

// *** logic/lac_led_test.sv ***
`timescale 1ns/1ps
module lac_led_test
  import lac_pkg::*;
#(
  parameter int PHASE_CYC = TEST_PHASE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Start pulse
  input wire logic start_i,
  // Test drive
  output logic red_o,
  output logic green_o,
  output logic busy_o
);

  typedef enum logic [1:0] {
    lt_idle,
    lt_red,
    lt_green
  } lac_lt_e;

  lac_lt_e state_reg;
  logic [31:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= lt_idle;
      cnt_reg <= 32'h0;
    end else if (start_i) begin
      state_reg <= lt_red;
      cnt_reg <= 32'h0;
    end else begin
      case (state_reg)
        lt_red: begin
          if (cnt_reg == 32'(PHASE_CYC - 1)) begin
            state_reg <= lt_green;
            cnt_reg <= 32'h0;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        lt_green: begin
          if (cnt_reg == 32'(PHASE_CYC - 1)) begin
            state_reg <= lt_idle;
            cnt_reg <= 32'h0;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        default: begin
          state_reg <= lt_idle;
          cnt_reg <= 32'h0;
        end
      endcase
    end
  end

  assign red_o = (state_reg == lt_red);
  assign green_o = (state_reg == lt_green);
  assign busy_o = (state_reg != lt_idle);

endmodule : lac_led_test

// *** logic/lac_ack_ctrl.sv ***
// Contract
// - Alarm clears LEDs marked acknowledge-by-alarm.
// - Remote requests need remote-acknowledge enable.
// - Collective commands per category and switchgear.
// - Combined command clears every category except the system warning.
// - Separate command clears system indicator warning.
// - Parameter mode: clear key acknowledges nothing.
// - Parameter mode: selection menu still usable.
// - Short press opens menu; wrench confirms.
// - One-second hold acknowledges scope immediately.
// - Long-press scope has five values.
// - Scope resets to indicators without password.
// - Indicator acknowledge runs red/green test.
// - Acknowledgments need password except two scopes.
// - Empty level-one password frees relays, SCADA, trip.
// - Latch clears only if source inactive.
// - Remote disabled: only panel acknowledgment works.
// - Relay latch released after off-delay.
`timescale 1ns/1ps
module lac_ack_ctrl
  import lac_pkg::*;
#(
  parameter int N_LED = 16,
  parameter int N_REL = 8,
  parameter int N_SCD = 8,
  parameter int N_SG = 4,
  parameter int LONG_CYC = LONG_PRESS_CYC,
  parameter int PHASE_CYC = TEST_PHASE_CYC,
  parameter int OFF_CYC = OFF_DELAY_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Panel
  input wire logic clear_key_i,
  input wire logic param_mode_i,
  input wire logic menu_enter_i,
  input wire logic menu_exit_i,
  input wire lac_cat_s softkey_i,
  input wire logic wrench_i,
  input wire logic password_ok_i,
  // Alarm and latch sources
  input wire logic alarm_i,
  input wire logic sys_warn_i,
  input wire logic [N_LED-1:0] led_set_i,
  input wire logic [N_REL-1:0] rel_set_i,
  input wire logic [N_SCD-1:0] scd_set_i,
  input wire logic [N_SG-1:0] trip_set_i,
  // Latched outputs, indicator test drive, menu state and clear pulses
  output logic sys_warn_o,
  output logic [N_LED-1:0] led_o,
  output logic [N_REL-1:0] rel_o,
  output logic [N_SCD-1:0] scd_o,
  output logic [N_SG-1:0] trip_o,
  output logic led_red_test_o,
  output logic led_green_test_o,
  output logic menu_open_o,
  output lac_cat_s clr_o
);
  // ****************************************
  // Declarations
  // ****************************************
  logic ack_reg;
  logic [31:0] dat_reg;
  logic remote_en_reg;
  lac_scope_e scope_reg;
  logic lv1_empty_reg;
  logic [N_LED-1:0] auto_reg;
  logic cmd_fire;
  logic [31:0] cmd_data;
  logic [31:0] bmask;
  logic wb_req;
  logic wb_wr;
  logic short_p;
  logic long_p;
  logic menu_reg;
  lac_cat_s msel_reg;
  lac_cat_s clr_reg;
  lac_cat_s clr_next;
  logic [N_SG-1:0] trip_sel_reg;
  logic [N_SG-1:0] trip_sel_next;
  logic alarm_d_reg;
  logic auto_clr_reg;
  logic sys_latch_reg;
  logic [N_LED-1:0] led_latch_reg;
  logic [N_REL-1:0] rel_latch_reg;
  logic [N_SCD-1:0] scd_latch_reg;
  logic [N_SG-1:0] trip_latch_reg;
  logic test_busy;
  logic [N_SG-1:0] sg_onehot;

  // ****************************************
  // Wishbone slave
  // ****************************************
  assign wb_req = cyc_i && stb_i;
  assign wb_wr = wb_req && we_i && ack_reg;
  assign bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req && !ack_reg;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0;
    end else if (wb_req && !ack_reg) begin
      dat_reg <= 32'h0;
      case (adr_i[4:2])
        ADR_CTRL: begin
          dat_reg[CTRL_REMOTE_EN] <= remote_en_reg;
          dat_reg[CTRL_SCOPE_LSB +: 3] <= scope_reg;
          dat_reg[CTRL_LV1_EMPTY] <= lv1_empty_reg;
        end
        ADR_AUTO: dat_reg[N_LED-1:0] <= auto_reg;
        ADR_LED_STAT: dat_reg[N_LED-1:0] <= led_latch_reg;
        ADR_MISC_STAT: begin
          dat_reg[ST_REL_LSB +: N_REL] <= rel_latch_reg;
          dat_reg[ST_SCD_LSB +: N_SCD] <= scd_latch_reg;
          dat_reg[ST_TRIP_LSB +: N_SG] <= trip_latch_reg;
          dat_reg[ST_MENU] <= menu_reg;
          dat_reg[ST_TEST] <= test_busy;
          dat_reg[ST_SYS] <= sys_latch_reg;
        end
        default: dat_reg <= 32'h0;
      endcase
    end
  end
  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  // ****************************************
  // Settings
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remote_en_reg <= 1'b0;
      scope_reg <= SCOPE_RESET;
      lv1_empty_reg <= 1'b0;
      auto_reg <= '0;
    end else if (wb_wr && adr_i[4:2] == ADR_CTRL) begin
      if (sel_i[0]) begin
        remote_en_reg <= dat_i[CTRL_REMOTE_EN];
        lv1_empty_reg <= dat_i[CTRL_LV1_EMPTY];
        if (dat_i[CTRL_SCOPE_LSB +: 3] <= 3'(scope_everything)) begin
          scope_reg <= lac_scope_e'(dat_i[CTRL_SCOPE_LSB +: 3]);
        end
      end
    end else if (wb_wr && adr_i[4:2] == ADR_AUTO) begin
      auto_reg <= N_LED'((32'(auto_reg) & ~bmask) | (dat_i & bmask));
    end
  end
  // Command word: write-only, one shot
  assign cmd_fire = wb_wr && adr_i[4:2] == ADR_CMD && remote_en_reg;
  assign cmd_data = dat_i;

  // ****************************************
  // Clear key and menu
  // ****************************************
  lac_key_press #(
    .LONG_CYC(LONG_CYC)
  ) u_key (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .key_pin_i(clear_key_i),
    .short_o(short_p),
    .long_o(long_p)
  );
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      menu_reg <= 1'b0;
      msel_reg <= '0;
    end else if (menu_reg) begin
      if (wrench_i || menu_exit_i) begin
        menu_reg <= 1'b0;
        msel_reg <= '0;
      end else begin
        msel_reg <= msel_reg ^ softkey_i;
      end
    end else if (menu_enter_i || (short_p && !param_mode_i)) begin
      menu_reg <= 1'b1;
      msel_reg <= '0;
    end
  end
  assign menu_open_o = menu_reg;

  // ****************************************
  // Request merge
  // ****************************************
  always_comb begin
    clr_next = '0;
    trip_sel_next = '0;
    // Panel menu confirm; indicators need a password
    if (menu_reg && wrench_i) begin
      clr_next.sys = msel_reg.sys;
      clr_next.led = msel_reg.led && password_ok_i;
      clr_next.rel = msel_reg.rel && (password_ok_i || lv1_empty_reg);
      clr_next.scd = msel_reg.scd && (password_ok_i || lv1_empty_reg);
      clr_next.trip = msel_reg.trip && (password_ok_i || lv1_empty_reg);
      if (clr_next.trip) begin
        trip_sel_next = '1;
      end
    end
    // Long press, suppressed in parameter mode
    if (long_p && !param_mode_i) begin
      case (scope_reg)
        scope_indicators_no_password: clr_next.led = 1'b1;
        scope_indicators_password: clr_next.led = clr_next.led || password_ok_i;
        scope_indicators_and_relays: begin
          clr_next.led = clr_next.led || password_ok_i;
          clr_next.rel = clr_next.rel || password_ok_i || lv1_empty_reg;
        end
        scope_everything: begin
          clr_next.led = clr_next.led || password_ok_i;
          clr_next.rel = clr_next.rel || password_ok_i || lv1_empty_reg;
          clr_next.scd = clr_next.scd || password_ok_i || lv1_empty_reg;
          if (password_ok_i || lv1_empty_reg) begin
            clr_next.trip = 1'b1;
            trip_sel_next = '1;
          end
        end
        default: ;
      endcase
    end
    // Remote collective commands
    if (cmd_fire) begin
      clr_next.sys = clr_next.sys || cmd_data[CMD_SYS];
      if (cmd_data[CMD_LED] || cmd_data[CMD_ALL]) begin
        clr_next.led = clr_next.led || password_ok_i;
      end
      if (password_ok_i || lv1_empty_reg) begin
        clr_next.rel = clr_next.rel || cmd_data[CMD_REL] || cmd_data[CMD_ALL];
        clr_next.scd = clr_next.scd || cmd_data[CMD_SCD] || cmd_data[CMD_ALL];
        if (cmd_data[CMD_ALL]) begin
          clr_next.trip = 1'b1;
          trip_sel_next = '1;
        end else if (cmd_data[CMD_TRIP]) begin
          clr_next.trip = 1'b1;
          trip_sel_next = trip_sel_next | sg_onehot;
        end
      end
    end
  end
  // Selected switchgear instance
  for (genvar g = 0; g < N_SG; g++) begin : g_sg
    assign sg_onehot[g] = (cmd_data[CMD_SG_LSB +: 4] == 4'(g));
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_reg <= '0;
      trip_sel_reg <= '0;
    end else begin
      clr_reg <= clr_next;
      trip_sel_reg <= trip_sel_next;
    end
  end
  assign clr_o = clr_reg;

  // ****************************************
  // Automatic alarm acknowledge
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_d_reg <= 1'b0;
      auto_clr_reg <= 1'b0;
    end else begin
      alarm_d_reg <= alarm_i;
      auto_clr_reg <= alarm_i && !alarm_d_reg && remote_en_reg;
    end
  end

  // ****************************************
  // Latches: set wins over clear
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_latch_reg <= 1'b0;
    end else if (sys_warn_i) begin
      sys_latch_reg <= 1'b1;
    end else if (clr_reg.sys) begin
      sys_latch_reg <= 1'b0;
    end
  end
  generate
    for (genvar i = 0; i < N_LED; i++) begin : g_led
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          led_latch_reg[i] <= 1'b0;
        end else if (led_set_i[i]) begin
          led_latch_reg[i] <= 1'b1;
        end else if (clr_reg.led || (auto_clr_reg && auto_reg[i])) begin
          led_latch_reg[i] <= 1'b0;
        end
      end
    end
    for (genvar i = 0; i < N_SCD; i++) begin : g_scd
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          scd_latch_reg[i] <= 1'b0;
        end else if (scd_set_i[i]) begin
          scd_latch_reg[i] <= 1'b1;
        end else if (clr_reg.scd) begin
          scd_latch_reg[i] <= 1'b0;
        end
      end
    end
    for (genvar i = 0; i < N_SG; i++) begin : g_trip
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          trip_latch_reg[i] <= 1'b0;
        end else if (trip_set_i[i]) begin
          trip_latch_reg[i] <= 1'b1;
        end else if (clr_reg.trip && trip_sel_reg[i]) begin
          trip_latch_reg[i] <= 1'b0;
        end
      end
    end
    for (genvar i = 0; i < N_REL; i++) begin : g_rel
      logic [31:0] off_cnt_reg;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          rel_latch_reg[i] <= 1'b0;
          off_cnt_reg <= 32'h0;
        end else if (rel_set_i[i]) begin
          rel_latch_reg[i] <= 1'b1;
          off_cnt_reg <= 32'h0;
        end else if (off_cnt_reg != 32'h0) begin
          off_cnt_reg <= off_cnt_reg - 32'h1;
          if (off_cnt_reg == 32'h1) begin
            rel_latch_reg[i] <= 1'b0;
          end
        end else if (clr_reg.rel && rel_latch_reg[i]) begin
          off_cnt_reg <= 32'(OFF_CYC);
        end
      end
    end
  endgenerate
  assign sys_warn_o = sys_latch_reg;
  assign led_o = led_latch_reg | led_set_i;
  assign rel_o = rel_latch_reg | rel_set_i;
  assign scd_o = scd_latch_reg | scd_set_i;
  assign trip_o = trip_latch_reg | trip_set_i;

  // ****************************************
  // Indicator test
  // ****************************************
  lac_led_test #(
    .PHASE_CYC(PHASE_CYC)
  ) u_test (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(clr_reg.led),
    .red_o(led_red_test_o),
    .green_o(led_green_test_o),
    .busy_o(test_busy)
  );

endmodule : lac_ack_ctrl

// *** testbench/lac_ack_monitor.sv ***
`timescale 1ns/1ps
module lac_ack_monitor
  import lac_pkg::*;
#(
  parameter int N_REL = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic sys_warn_i,
  input wire logic [N_REL-1:0] rel_set_i,
  input wire logic menu_enter_i,
  input wire logic wrench_i,
  input wire logic sys_warn_o,
  input wire logic [N_REL-1:0] rel_o,
  input wire logic led_red_test_o,
  input wire logic led_green_test_o,
  input wire logic menu_open_o,
  input wire lac_cat_s clr_o
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence red_run;
    (led_red_test_o && !led_green_test_o) [*8];
  endsequence
  sequence green_on;
    led_green_test_o && !led_red_test_o;
  endsequence
  ack_after_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered");
  ack_once_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  clr_single_a: assert property (clr_o != '0 |=> clr_o == '0)
    else $error("clear pulse too long");
  sys_hold_a: assert property (clr_o.sys && sys_warn_i |=> sys_warn_o)
    else $error("system warning cleared while source active");
  sys_clear_a: assert property (clr_o.sys && !sys_warn_i |=> !sys_warn_o)
    else $error("system warning not cleared");
  rel_delay_a: assert property (clr_o.rel && rel_set_i == '0 && rel_o != '0
    |=> (rel_o != '0) [*3] ##[1:4] (rel_o == '0)) else $error("relay off-delay wrong");
  test_start_a: assert property (clr_o.led |-> ##[1:2] led_red_test_o)
    else $error("indicator test not started");
  test_phase_a: assert property ($rose(led_red_test_o) |-> red_run ##[1:4] green_on)
    else $error("indicator test phases wrong");
  menu_enter_a: assert property (menu_enter_i && !menu_open_o |=> menu_open_o)
    else $error("menu did not open");
  menu_confirm_a: assert property (menu_open_o && wrench_i |=> !menu_open_o)
    else $error("menu did not close on confirm");
endmodule : lac_ack_monitor

bind lac_ack_ctrl lac_ack_monitor #(.N_REL(N_REL)) u_mon (.clk_i, .rst_i, .cyc_i, .stb_i,
  .ack_o, .sys_warn_i, .rel_set_i, .menu_enter_i, .wrench_i, .sys_warn_o, .rel_o,
  .led_red_test_o, .led_green_test_o, .menu_open_o, .clr_o);

// *** testbench/lac_panel_model.sv ***
`timescale 1ns/1ps
module lac_panel_model
  import lac_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Panel keys
  output logic key_o,
  output logic enter_o,
  output logic exit_o,
  output lac_cat_s soft_o,
  output logic wrench_o
);
  // ****************************************
  // Operator actions
  // ****************************************
  initial begin
    key_o = 1'b0;
    enter_o = 1'b0;
    exit_o = 1'b0;
    soft_o = '0;
    wrench_o = 1'b0;
  end
  task automatic hold_key(input int n);
    @(posedge clk_i) key_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    key_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask : hold_key
  task automatic menu_key(input logic ex);
    @(posedge clk_i) enter_o <= !ex;
    exit_o <= ex;
    @(posedge clk_i) enter_o <= 1'b0;
    exit_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask : menu_key
  // Select first, then confirm with wrench
  task automatic menu_pick(input lac_cat_s pick);
    @(posedge clk_i) soft_o <= pick;
    @(posedge clk_i) soft_o <= '0;
    wrench_o <= 1'b1;
    @(posedge clk_i) wrench_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask : menu_pick
endmodule : lac_panel_model

// *** testbench/test_latch_acknowledge_control.sv ***
`timescale 1ns/1ps
module test_latch_acknowledge_control;
  import lac_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [4:0] adr_i;
  logic [3:0] sel_i;
  logic [3:0] wsel = 4'hf;
  logic [31:0] dat_i, dat_o, rd;
  logic clear_key_i, param_mode_i, menu_enter_i, menu_exit_i, wrench_i, password_ok_i;
  lac_cat_s softkey_i, clr_o;
  logic alarm_i, sys_warn_i, sys_warn_o, led_red_test_o, led_green_test_o, menu_open_o;
  logic [15:0] led_set_i, led_o;
  logic [7:0] rel_set_i, rel_o, scd_set_i, scd_o;
  logic [3:0] trip_set_i, trip_o;
  int miscompares = 0;
  int n_checks = 0;

  lac_ack_ctrl #(.LONG_CYC(20), .PHASE_CYC(10), .OFF_CYC(5)) DUT (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .clear_key_i, .param_mode_i,
    .menu_enter_i, .menu_exit_i, .softkey_i, .wrench_i, .password_ok_i, .alarm_i,
    .sys_warn_i, .led_set_i, .rel_set_i, .scd_set_i, .trip_set_i, .sys_warn_o, .led_o,
    .rel_o, .scd_o, .trip_o, .led_red_test_o, .led_green_test_o, .menu_open_o, .clr_o);
  lac_panel_model u_panel (.clk_i, .key_o(clear_key_i), .enter_o(menu_enter_i),
    .exit_o(menu_exit_i), .soft_o(softkey_i), .wrench_o(wrench_i));

  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  function automatic logic [4:0] ba(input logic [2:0] w);
    return {w, 2'b00};
  endfunction : ba
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : idle
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i) {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, wsel};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 50);
    if (t >= 50) begin
      miscompares++;
      $display("mismatch at %0t: no bus answer", $time);
    end
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb
  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic latch_all();
    @(posedge clk_i) {led_set_i, rel_set_i, scd_set_i, trip_set_i, sys_warn_i} <= '1;
    @(posedge clk_i) {led_set_i, rel_set_i, scd_set_i, trip_set_i, sys_warn_i} <= '0;
  endtask : latch_all
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, param_mode_i, password_ok_i} = '0;
    {alarm_i, sys_warn_i, led_set_i, rel_set_i, scd_set_i, trip_set_i} = '0;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(ba(ADR_CTRL), 32'h2);
    rdchk(ba(ADR_AUTO), 32'h0);
    rdchk(5'h14, 32'h0);
    latch_all();
    rdchk(ba(ADR_MISC_STAT), 32'h040fffff);
    wb(1'b1, ba(ADR_CMD), 32'h20);
    rdchk(ba(ADR_LED_STAT), 32'hffff);
    wb(1'b1, ba(ADR_CTRL), 32'h9);
    wb(1'b1, ba(ADR_CMD), 32'h4);
    idle(12);
    chk({24'h0, rel_o}, 32'hff);
    wb(1'b1, ba(ADR_CTRL), 32'h19);
    @(posedge clk_i) rel_set_i <= 8'h01;
    wb(1'b1, ba(ADR_CMD), 32'h4);
    idle(2);
    chk({24'h0, rel_o}, 32'hff);
    idle(10);
    @(posedge clk_i) rel_set_i <= 8'h00;
    idle(1);
    chk({24'h0, rel_o}, 32'h01);
    @(posedge clk_i) sys_warn_i <= 1'b1;
    wb(1'b1, ba(ADR_CMD), 32'h1);
    idle(2);
    chk({31'h0, sys_warn_o}, 32'h1);
    @(posedge clk_i) sys_warn_i <= 1'b0;
    wb(1'b1, ba(ADR_CMD), 32'h1);
    idle(2);
    chk({15'h0, sys_warn_o, led_o}, 32'hffff);
    @(posedge clk_i) scd_set_i <= 8'h01;
    wb(1'b1, ba(ADR_CMD), 32'h8);
    @(posedge clk_i) scd_set_i <= 8'h00;
    idle(2);
    chk({24'h0, scd_o}, 32'h01);
    wb(1'b1, ba(ADR_CMD), 32'h210);
    idle(2);
    chk({28'h0, trip_o}, 32'hb);
    @(posedge clk_i) password_ok_i <= 1'b1;
    wb(1'b1, ba(ADR_CMD), 32'h2);
    idle(3);
    chk({led_o, 15'h0, led_red_test_o}, 32'h1);
    idle(12);
    chk({31'h0, led_green_test_o}, 32'h1);
    latch_all();
    @(posedge clk_i) trip_set_i <= 4'h8;
    wb(1'b1, ba(ADR_CMD), 32'h20);
    @(posedge clk_i) trip_set_i <= 4'h0;
    idle(12);
    chk({led_o, rel_o, scd_o}, 32'h0);
    chk({28'h0, trip_o}, 32'h8);
    for (int s = 0; s < 5; s++) begin
      latch_all();
      @(posedge clk_i) password_ok_i <= (s != 1);
      wb(1'b1, ba(ADR_CTRL), 32'(s) << 1);
      u_panel.hold_key(30);
      idle(15);
      chk({led_o, rel_o, scd_o}, {s > 0 ? 16'h0 : 16'hffff,
        s > 3 ? 16'h0 : s > 2 ? 16'h00ff : 16'hffff});
      u_panel.menu_key(1'b1);
    end
    latch_all();
    wb(1'b1, ba(ADR_CTRL), 32'h2);
    @(posedge clk_i) param_mode_i <= 1'b1;
    u_panel.hold_key(30);
    chk({16'h0, led_o}, 32'hffff);
    u_panel.hold_key(5);
    chk({31'h0, menu_open_o}, 32'h0);
    u_panel.menu_key(1'b0);
    chk({31'h0, menu_open_o}, 32'h1);
    u_panel.menu_pick(lac_cat_s'(5'h08));
    chk({15'h0, menu_open_o, led_o}, 32'h0);
    @(posedge clk_i) param_mode_i <= 1'b0;
    u_panel.hold_key(5);
    chk({31'h0, menu_open_o}, 32'h1);
    u_panel.menu_key(1'b1);
    wb(1'b1, ba(ADR_CTRL), 32'he);
    rdchk(ba(ADR_CTRL), 32'h2);
    wsel = 4'h1;
    wb(1'b1, ba(ADR_AUTO), 32'hff03);
    wsel = 4'hf;
    rdchk(ba(ADR_AUTO), 32'h3);
    idle(25);
    latch_all();
    @(posedge clk_i) alarm_i <= 1'b1;
    idle(4);
    chk({16'h0, led_o}, 32'hffff);
    wb(1'b1, ba(ADR_CTRL), 32'h3);
    @(posedge clk_i) {alarm_i, led_set_i} <= 17'h00002;
    @(posedge clk_i) alarm_i <= 1'b1;
    idle(4);
    chk({16'h0, led_o}, 32'hfffe);
    give_verdict();
  end
endmodule : test_latch_acknowledge_control
